//--- src/pli_pkg.sv
/*
 Shared constants, encodings and carriers of the proximity and ambient result and
 interrupt logic. Assumes nothing of its surroundings.
*/
package pli_pkg;
   // Command codes of the 16-bit registers.
   localparam logic [7:0] CMD_ACONF = 8'h00;
   localparam logic [7:0] CMD_ATHH = 8'h01;
   localparam logic [7:0] CMD_ATHL = 8'h02;
   localparam logic [7:0] CMD_PCONF = 8'h03;
   localparam logic [7:0] CMD_PCONF3 = 8'h04;
   localparam logic [7:0] CMD_PCANC = 8'h05;
   localparam logic [7:0] CMD_PTHL = 8'h06;
   localparam logic [7:0] CMD_PTHH = 8'h07;
   localparam logic [7:0] CMD_PRES = 8'h08;
   localparam logic [7:0] CMD_ARES = 8'h09;
   localparam logic [7:0] CMD_WRES = 8'h0A;
   localparam logic [7:0] CMD_FLAG = 8'h0B;
   localparam int CFG_DEPTH = 8;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // Field positions.
   localparam int AMB_EN_BIT = 1;
   localparam int AMB_PERS_LO = 2;
   localparam int PRX_PERS_LO = 4;
   localparam int PRX_SEL_LO = 8;
   localparam int TRIG_BIT = 2;
   localparam int FORCE_BIT = 3;
   localparam int MODE_BIT = 14;
   // Interrupt flag byte, bit positions within the high byte.
   localparam int FLG_PROT = 6;
   localparam int FLG_ALO = 5;
   localparam int FLG_AHI = 4;
   localparam int FLG_CLOSE = 1;
   localparam int FLG_AWAY = 0;
   localparam logic [7:0] FLAG_NONE = 8'h00;
   localparam logic [6:0] PLI_SLAVE_ADDR = 7'h60;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   // One measurement with its strobe.
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } pli_sample_s;
   // Serial slave states.
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK = 6'h04,
      ST_RX = 6'h08,
      ST_TX = 6'h10,
      ST_MACK = 6'h20
   } pli_i2c_e;
endpackage

//--- src/pli_sync.sv
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes the inputs are asynchronous to mclk and change slowly against it.
*/
`timescale 1ns/1ns
module pli_sync #(
   parameter int W = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;
   // Each bit passes two flip-flops; the first is read only by the second.
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            meta[i] <= 1'b1;
            sync_out[i] <= 1'b1;
         end else begin
            meta[i] <= async_in[i];
            sync_out[i] <= meta[i];
         end
      end
   end
endmodule // pli_sync

//--- src/pli_window.sv
/*
 Threshold window with persistence: counts consecutive samples above the high
 threshold or below the low one and pulses an event when the count reaches its target.
 Assumes samples arrive on mclk as one-cycle strobes.
*/
`timescale 1ns/1ns
module pli_window (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sample_valid,
   input wire logic [15:0] value,
   input wire logic [15:0] high_thr,
   input wire logic [15:0] low_thr,
   input wire logic [3:0] target,
   output logic high_event,
   output logic low_event
);
   logic [3:0] cnt_hi;
   logic [3:0] cnt_lo;
   logic [3:0] inc_hi;
   logic [3:0] inc_lo;
   assign inc_hi = cnt_hi + 4'h1;
   assign inc_lo = cnt_lo + 4'h1;
   // A miss restarts the count; the event fires once, when the run reaches the target.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_hi <= 4'h0;
         cnt_lo <= 4'h0;
         high_event <= 1'b0;
         low_event <= 1'b0;
      end else begin
         high_event <= sample_valid && (value > high_thr) && (inc_hi == target);
         low_event <= sample_valid && (value < low_thr) && (inc_lo == target);
         if (sample_valid) begin
            cnt_hi <= (value > high_thr) ? ((cnt_hi == target) ? cnt_hi : inc_hi) : 4'h0;
            cnt_lo <= (value < low_thr) ? ((cnt_lo == target) ? cnt_lo : inc_lo) : 4'h0;
         end
      end
   end
endmodule // pli_window

//--- src/pli_core.sv
/*
 Result handling, threshold interrupts and serial register slave of a proximity and
 ambient light sensor. Assumes the front end delivers samples on mclk and that the
 serial pins are synchronised here; the pins are open-drain and pulled up outside.
*/
// How it works
// - Proximity event after 1 to 4 consecutive hits
// - Force mode keeps proximity in standby
// - Trigger write yields exactly one measurement
// - Every command register reads back its contents, except the PCONF3 trigger bit, which reads the pending one-shot
// - Results are two bytes, high and low
// - Crosstalk offset subtracted from raw proximity
// - Enabled events pull the pin low, outside logic mode
// - Registers stay accessible while pin asserted
// - Ambient event above high or below low
// - Close above high, away below low
// - Selection picks close, away, both or none
// - Any flag rising pulls pin low, outside logic mode
// - Reading flags clears them, releases pin outside logic mode
// - Logic mode: pin low while object near
// - Logic mode pin ignores ambient events
// - Logic mode needs a proximity selection
// - Flags hold and block events until read
// - Ambient event after 1,2,4,8 hits
// - Flag byte bit layout fixed
`timescale 1ns/1ns
module pli_core #(
   parameter logic [6:0] SLAVE_ADDR = pli_pkg::PLI_SLAVE_ADDR
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic int_n,
   input wire pli_pkg::pli_sample_s prox_raw,
   input wire pli_pkg::pli_sample_s ambient_raw,
   input wire pli_pkg::pli_sample_s white_raw,
   input wire logic prox_protection_event,
   output logic prox_standby,
   output logic prox_meas_request
);
   import pli_pkg::*;

   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   pli_i2c_e state;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic [1:0] byte_idx;
   logic is_read;
   logic [7:0] cmd;
   logic [7:0] wr_lo;
   logic [7:0] rd_hi;
   logic wr_commit;
   logic [15:0] wr_data;
   logic flag_clear;
   logic [15:0] rd_val;
   logic [7:0] tx_byte;
   logic [15:0] cfg [0:CFG_DEPTH-1];
   logic trig;
   logic trig_set;
   logic force_mode;
   logic prox_take;
   logic [15:0] prox_sub;
   logic [15:0] prox_result;
   logic [15:0] ambient_light_result;
   logic [15:0] white_result;
   logic amb_hi_ev;
   logic amb_lo_ev;
   logic close_ev;
   logic away_ev;
   logic [3:0] amb_target;
   logic [3:0] prx_target;
   logic amb_en;
   logic [1:0] prox_irq_select;
   logic logic_mode;
   logic [7:0] ev;
   logic [7:0] flags;
   logic [7:0] next_flags;
   logic near;

   // Serial pins are asynchronous and pass two flip-flops first.
   pli_sync #(.W(2)) u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .async_in({scl_in, sda_in}),
      .sync_out(pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // Edge and bus-condition detection on the synchronised pins.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_c = scl_s && scl_d && sda_d && !sda_s;
   assign stop_c = scl_s && scl_d && !sda_d && sda_s;

   // Byte sent to the master: low byte first, then the high byte latched with it.
   assign tx_byte = (byte_idx == 2'h0) ? rd_val[7:0] : rd_hi;
   assign wr_data = {shreg, wr_lo};

   // Serial slave: address, command code, then data low byte and high byte.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         byte_idx <= 2'h0;
         is_read <= 1'b0;
         cmd <= 8'h00;
         wr_lo <= 8'h00;
         rd_hi <= 8'h00;
         wr_commit <= 1'b0;
         flag_clear <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         wr_commit <= 1'b0;
         flag_clear <= 1'b0;
         if (start_c) begin
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            byte_idx <= 2'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state)
               ST_ADDR, ST_RX: begin
                  if (scl_rise && bitcnt != BITS_BYTE) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == BITS_BYTE) begin
                     if (state == ST_ADDR) begin
                        if (shreg[7:1] == SLAVE_ADDR) begin
                           state <= ST_ACK;
                           sda_oe_n <= 1'b0;
                           is_read <= shreg[0];
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        state <= ST_ACK;
                        sda_oe_n <= 1'b0;
                        if (byte_idx == 2'h0) begin
                           cmd <= shreg;
                        end else if (byte_idx == 2'h1) begin
                           wr_lo <= shreg;
                        end else if (byte_idx == 2'h2) begin
                           wr_commit <= 1'b1;
                        end
                        if (byte_idx != 2'h3) begin
                           byte_idx <= byte_idx + 2'h1;
                        end
                     end
                  end
               end
               ST_ACK, ST_MACK: begin
                  if (state == ST_MACK && scl_rise && sda_s) begin
                     state <= ST_IDLE;
                  end else if (scl_fall) begin
                     bitcnt <= 4'h0;
                     if (is_read) begin
                        state <= ST_TX;
                        shreg <= tx_byte;
                        sda_oe_n <= tx_byte[7];
                        if (byte_idx == 2'h0) begin
                           rd_hi <= rd_val[15:8];
                        end else if (byte_idx == 2'h1 && cmd == CMD_FLAG) begin
                           flag_clear <= 1'b1;
                        end
                        if (byte_idx != 2'h3) begin
                           byte_idx <= byte_idx + 2'h1;
                        end
                     end else begin
                        state <= ST_RX;
                        sda_oe_n <= 1'b1;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == BIT_LAST) begin
                        state <= ST_MACK;
                        sda_oe_n <= 1'b1;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe_n <= shreg[6];
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // The open-drain data pin only ever drives low.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Configuration registers, one storage word per command code.
   for (genvar i = 0; i < CFG_DEPTH; i++) begin : g_cfg
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            cfg[i] <= CFG_RESET;
         end else if (wr_commit && cmd == 8'(i)) begin
            cfg[i] <= wr_data;
         end
      end
   end

   // Read multiplexer; every register returns its current contents, except the trigger bit, which returns the pending one-shot.
   always_comb begin
      rd_val = 16'h0000;
      if (cmd < 8'(CFG_DEPTH)) begin
         rd_val = cfg[cmd[2:0]];
      end
      case (cmd)
         CMD_PCONF3: rd_val[TRIG_BIT] = trig;
         CMD_PRES: rd_val = prox_result;
         CMD_ARES: rd_val = ambient_light_result;
         CMD_WRES: rd_val = white_result;
         CMD_FLAG: rd_val = {flags, 8'h00};
         default: rd_val = rd_val;
      endcase
   end

   // Configuration fields.
   assign amb_en = cfg[CMD_ACONF[2:0]][AMB_EN_BIT];
   assign amb_target = 4'h1 << cfg[CMD_ACONF[2:0]][AMB_PERS_LO+:2];
   assign prx_target = {2'b00, cfg[CMD_PCONF[2:0]][PRX_PERS_LO+:2]} + 4'h1;
   assign prox_irq_select = cfg[CMD_PCONF[2:0]][PRX_SEL_LO+:2];
   assign force_mode = cfg[CMD_PCONF3[2:0]][FORCE_BIT];
   assign logic_mode = cfg[CMD_PCONF3[2:0]][MODE_BIT] && (prox_irq_select != 2'b00);

   // One-shot request: set by a trigger write in force mode, cleared by the sample taken.
   assign trig_set = wr_commit && cmd == CMD_PCONF3 && wr_data[TRIG_BIT] && wr_data[FORCE_BIT];
   assign prox_take = prox_raw.valid && (!force_mode || trig);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         trig <= 1'b0;
         prox_meas_request <= 1'b0;
         prox_standby <= 1'b0;
      end else begin
         prox_meas_request <= trig_set;
         prox_standby <= force_mode;
         if (trig_set) begin
            trig <= 1'b1;
         end else if (prox_take) begin
            trig <= 1'b0;
         end
      end
   end

   // Crosstalk offset removed, clamped at zero so a small reading cannot wrap.
   always_comb begin
      prox_sub = 16'h0000;
      if (prox_raw.value > cfg[CMD_PCANC[2:0]]) begin
         prox_sub = prox_raw.value - cfg[CMD_PCANC[2:0]];
      end
   end

   // Result registers.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prox_result <= 16'h0000;
         ambient_light_result <= 16'h0000;
         white_result <= 16'h0000;
      end else begin
         if (prox_take) begin
            prox_result <= prox_sub;
         end
         if (ambient_raw.valid) begin
            ambient_light_result <= ambient_raw.value;
         end
         if (white_raw.valid) begin
            white_result <= white_raw.value;
         end
      end
   end

   // Ambient window with persistence.
   pli_window u_amb_win (
      .mclk(mclk),
      .rstn(rstn),
      .sample_valid(ambient_raw.valid),
      .value(ambient_raw.value),
      .high_thr(cfg[CMD_ATHH[2:0]]),
      .low_thr(cfg[CMD_ATHL[2:0]]),
      .target(amb_target),
      .high_event(amb_hi_ev),
      .low_event(amb_lo_ev)
   );

   // Proximity window with persistence on the corrected value.
   pli_window u_prx_win (
      .mclk(mclk),
      .rstn(rstn),
      .sample_valid(prox_take),
      .value(prox_sub),
      .high_thr(cfg[CMD_PTHH[2:0]]),
      .low_thr(cfg[CMD_PTHL[2:0]]),
      .target(prx_target),
      .high_event(close_ev),
      .low_event(away_ev)
   );

   // Enabled events in flag-byte positions.
   always_comb begin
      ev = FLAG_NONE;
      ev[FLG_PROT] = prox_protection_event;
      ev[FLG_ALO] = amb_lo_ev && amb_en;
      ev[FLG_AHI] = amb_hi_ev && amb_en;
      ev[FLG_CLOSE] = close_ev && prox_irq_select[0];
      ev[FLG_AWAY] = away_ev && prox_irq_select[1];
   end

   // Flags hold until read; while any is set new events are ignored, but an
   // event landing on the clearing read is kept.
   always_comb begin
      next_flags = flags;
      if (flag_clear) begin
         next_flags = ev;
      end else if (flags == FLAG_NONE) begin
         next_flags = ev;
      end
   end

   // Flags, near state and the interrupt pin.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags <= FLAG_NONE;
         near <= 1'b0;
         int_n <= 1'b1;
      end else begin
         flags <= next_flags;
         if (close_ev) begin
            near <= 1'b1;
         end else if (away_ev) begin
            near <= 1'b0;
         end
         if (logic_mode) begin
            int_n <= !near;
         end else begin
            int_n <= (flags == FLAG_NONE);
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   flag_read_clear_a: assert property (flag_clear && ev == FLAG_NONE |=> flags == FLAG_NONE)
      else $error("flags not cleared by read");
   pin_from_flags_a: assert property (!logic_mode |=> int_n == ($past(flags) == FLAG_NONE))
      else $error("pin does not follow flags");
   pin_near_a: assert property (logic_mode |=> int_n == !$past(near))
      else $error("pin does not follow near state");
   flag_hold_a: assert property (flags != FLAG_NONE && !flag_clear |=> $stable(flags))
      else $error("flags changed before read");
   prox_offset_a: assert property (prox_take |=> prox_result == $past(prox_sub))
      else $error("proximity result not offset value");
   force_block_a: assert property (force_mode && !trig |=> $stable(prox_result))
      else $error("measurement taken in standby");
   oneshot_clear_a: assert property (prox_take && force_mode && !trig_set |=> !trig)
      else $error("trigger not cleared after one shot");
   amb_gate_a: assert property ($rose(flags[FLG_AHI]) |-> $past(amb_en))
      else $error("ambient flag while disabled");
   close_gate_a: assert property ($rose(flags[FLG_CLOSE]) |-> $past(prox_irq_select[0]))
      else $error("close flag while not selected");

   force_shot_c: cover property (trig_set ##[1:50] prox_take);
   flag_read_c: cover property (flags != FLAG_NONE ##1 flag_clear);
   near_pin_c: cover property (logic_mode && near ##1 !int_n);
endmodule // pli_core

//--- verif/pli_host.sv
/*
 Host model: a plain serial bus master that reads and writes 16-bit registers.
 Assumes the data wire is resolved with a pull-up outside and fed back on sda_wire.
*/
`timescale 1ns/1ns
module pli_host (
   input wire logic mclk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda
);
   // Idle bus: both lines released high.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Waits a number of falling mclk edges.
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Drives one bit (1 releases) and samples the wire in the middle of the high phase.
   task automatic clk_bit(input logic b, output logic s);
      sda = b;
      tick(4);
      scl = 1'b1;
      tick(4);
      s = sda_wire;
      tick(4);
      scl = 1'b0;
      tick(4);
   endtask
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      sda = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda = 1'b0;
      tick(4);
      scl = 1'b0;
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      sda = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda = 1'b1;
      tick(8);
   endtask
   // One byte MSB first, then the ninth bit (released, or our ACK or NACK on reads).
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
         q[i] = s;
      end
      clk_bit(last, s);
   endtask
   // Register write: address, command, low byte, high byte.
   task automatic write_reg(input logic [7:0] cmd, input logic [15:0] d);
      logic [7:0] q;
      start();
      xfer({pli_pkg::PLI_SLAVE_ADDR, 1'b0}, 1'b1, q);
      xfer(cmd, 1'b1, q);
      xfer(d[7:0], 1'b1, q);
      xfer(d[15:8], 1'b1, q);
      stop();
   endtask
   // Register read: command, repeated start, low byte acked, high byte refused.
   task automatic read_reg(input logic [7:0] cmd, output logic [15:0] d);
      logic [7:0] q;
      logic [7:0] lo;
      start();
      xfer({pli_pkg::PLI_SLAVE_ADDR, 1'b0}, 1'b1, q);
      xfer(cmd, 1'b1, q);
      start();
      xfer({pli_pkg::PLI_SLAVE_ADDR, 1'b1}, 1'b1, q);
      xfer(8'hFF, 1'b0, lo);
      xfer(8'hFF, 1'b1, q);
      d = {q, lo};
      stop();
   endtask
endmodule // pli_host

//--- verif/tb.sv
/*
 Self-checking bench of the result and interrupt core, driven through the host model.
 Assumes the open-drain data wire and the interrupt pin are pulled up on the board.
*/
`timescale 1ns/1ns
module tb;
   import pli_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic prot = 1'b0;
   logic scl, sda_h, sda_out, sda_oe_n, int_n, prox_standby, prox_meas_request;
   wire logic sda_wire;
   pli_sample_s prox_raw = '0, ambient_raw = '0, white_raw = '0;
   int n_fail = 0, n_tests = 0, cycles = 0, n_req = 0, hits;
   int seed = 32'hd0e3379b;
   logic [15:0] rd, v, off;
   // The wire is low when either party pulls it.
   assign sda_wire = sda_h & (sda_oe_n | sda_out);
   pli_host u_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda(sda_h));
   pli_core u_dut (.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_n(int_n), .prox_raw(prox_raw),
      .ambient_raw(ambient_raw), .white_raw(white_raw), .prox_protection_event(prot),
      .prox_standby(prox_standby), .prox_meas_request(prox_meas_request));
   // Free-running 10 MHz clock.
   initial begin
      forever #50 mclk = ~mclk;
   end
   // Counts measurement requests and cuts a hang short.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (prox_meas_request === 1'b1) n_req <= n_req + 1;
      if (cycles == 80000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      u_host.write_reg(c, d);
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
      u_host.read_reg(c, rd);
      check($sformatf("register %h", c), exp, rd);
   endtask
   // One-cycle sample strobe on channel k (0 proximity, 1 ambient, 2 white), then settle.
   task automatic samp(input int k, input logic [15:0] val);
      @(negedge mclk);
      prox_raw = {k == 0, val};
      ambient_raw = {k == 1, val};
      white_raw = {k == 2, val};
      @(negedge mclk);
      prox_raw.valid = 1'b0;
      ambient_raw.valid = 1'b0;
      white_raw.valid = 1'b0;
      repeat (5) @(negedge mclk);
   endtask
   // Expected proximity result: raw value less the offset, floored at zero.
   function automatic logic [15:0] exp_prox(input logic [15:0] raw, input logic [15:0] ofs);
      return (raw > ofs) ? raw - ofs : 16'h0000;
   endfunction
   // Main sequence.
   initial begin
      repeat (4) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      check("int_n", 1'b1, int_n);
      for (int c = 0; c < 12; c++) rdchk(8'(c), 16'h0000);
      // Random values read back from codes 1, 2, 5, 6 and 7; unmapped code reads 0.
      for (int c = 1; c < 8; c++) begin
         if (c == 3 || c == 4) continue;
         v = 16'($random(seed));
         wr(8'(c), v);
         rdchk(8'(c), v);
      end
      wr(8'h0C, 16'h5A5A);
      rdchk(8'h0C, 16'h0000);
      v = 16'($random(seed));
      samp(2, v);
      rdchk(CMD_WRES, v);
      // Crosstalk offset, including a raw value below the offset.
      off = 16'($random(seed)) & 16'h0FFF;
      v = (16'($random(seed)) & 16'h7FFF) | 16'h1000;
      wr(CMD_PCANC, off);
      samp(0, v);
      rdchk(CMD_PRES, exp_prox(v, off));
      samp(0, off >> 1);
      rdchk(CMD_PRES, exp_prox(off >> 1, off));
      wr(CMD_PCANC, 16'h0000);
      // Protection event raises bit 6.
      @(negedge mclk) prot = 1'b1;
      @(negedge mclk) prot = 1'b0;
      repeat (5) @(negedge mclk);
      check("int_n", 1'b0, int_n);
      rdchk(CMD_FLAG, 16'h4000);
      // Ambient window: equal value is a miss and restarts the count; 2 and 8 hits.
      wr(CMD_ATHH, 16'h8000);
      wr(CMD_ATHL, 16'h1000);
      for (int p = 1; p <= 3; p += 2) begin
         hits = 1 << p;
         v = (p == 1) ? 16'h9000 : 16'h0800;
         wr(CMD_ACONF, 16'(2 | (p << 2)));
         repeat (hits - 1) samp(1, v);
         samp(1, (p == 1) ? 16'h8000 : 16'h1000);
         repeat (hits - 1) samp(1, v);
         check("int_n", 1'b1, int_n);
         samp(1, v);
         check("int_n", 1'b0, int_n);
         rdchk(CMD_ARES, v);
         rdchk(CMD_FLAG, (p == 1) ? 16'h1000 : 16'h2000);
         check("int_n", 1'b1, int_n);
      end
      // Proximity close with 3 hits; the away event is ignored while the close flag is held.
      wr(CMD_ACONF, 16'h0000);
      wr(CMD_PTHL, 16'h0100);
      wr(CMD_PTHH, 16'h0400);
      wr(CMD_PCONF, 16'h0320);
      repeat (2) samp(0, 16'h0500);
      check("int_n", 1'b1, int_n);
      samp(0, 16'h0500);
      check("int_n", 1'b0, int_n);
      repeat (3) samp(0, 16'h0050);
      rdchk(CMD_FLAG, 16'h0200);
      wr(CMD_PCONF, 16'h0220);
      repeat (3) samp(0, 16'h0500);
      check("int_n", 1'b1, int_n);
      repeat (3) samp(0, 16'h0050);
      check("int_n", 1'b0, int_n);
      rdchk(CMD_FLAG, 16'h0100);
      // Force mode: standby, one measurement per trigger write.
      wr(CMD_PCONF, 16'h0000);
      wr(CMD_PCONF3, 16'h0008);
      check("prox_standby", 1'b1, prox_standby);
      samp(0, 16'h0777);
      rdchk(CMD_PRES, 16'h0050);
      wr(CMD_PCONF3, 16'h000C);
      check("requests", 16'h0001, 16'(n_req));
      samp(0, 16'h0321);
      rdchk(CMD_PRES, 16'h0321);
      rdchk(CMD_PCONF3, 16'h0008);
      samp(0, 16'h0999);
      rdchk(CMD_PRES, 16'h0321);
      // Logic output mode: pin follows near and far, and a set ambient flag stays off it.
      wr(CMD_PCONF3, 16'h4000);
      wr(CMD_PCONF, 16'h0300);
      wr(CMD_ACONF, 16'h0002);
      samp(0, 16'h0500);
      check("int_n", 1'b0, int_n);
      rdchk(CMD_FLAG, 16'h0200);
      check("int_n", 1'b0, int_n);
      samp(0, 16'h0050);
      check("int_n", 1'b1, int_n);
      rdchk(CMD_FLAG, 16'h0100);
      samp(1, 16'h9000);
      check("int_n", 1'b1, int_n);
      wr(CMD_PCONF, 16'h0000);
      check("int_n", 1'b0, int_n);
      rdchk(CMD_FLAG, 16'h1000);
      samp(0, 16'h0500);
      check("int_n", 1'b1, int_n);
      finish_test();
   end
endmodule // tb
